// ### rtl/aucal_pkg.sv
// Shared constants and types of the user calibration and register check block.
package aucal_pkg;
  localparam int DATA_W = 24;
  localparam int GAIN_SHIFT = 22;
  localparam int IDX_W = 6;
  localparam int ST_W = 2;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_OFFSET_HIGH = 6'h09;
  localparam logic [5:0] IDX_OFFSET_MID = 6'h0A;
  localparam logic [5:0] IDX_OFFSET_LOW = 6'h0B;
  localparam logic [5:0] IDX_GAIN_HIGH = 6'h0C;
  localparam logic [5:0] IDX_GAIN_MID = 6'h0D;
  localparam logic [5:0] IDX_GAIN_LOW = 6'h0E;
  localparam logic [5:0] IDX_CHECK = 6'h0F;
  localparam logic [5:0] IDX_CONTROL = 6'h10;
  localparam logic [5:0] IDX_STATUS = 6'h11;
  localparam logic [5:0] IDX_MASK = 6'h12;
  localparam logic [5:0] IDX_RESULT = 6'h13;
  localparam logic [7:0] OFFSET_RESET = 8'h00;
  localparam logic [7:0] GAIN_HIGH_RESET = 8'h40;
  localparam logic [7:0] GAIN_MID_RESET = 8'h00;
  localparam logic [7:0] GAIN_LOW_RESET = 8'h00;
  localparam logic [7:0] CHECK_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam int CTRL_CHECK_EN_BIT = 0;
  localparam int ST_REG_ERR_BIT = 0;
  localparam int ST_DATA_READY_BIT = 1;
  localparam int HDR_REG_ERR_BIT = 2;
  localparam logic [23:0] GAIN_UNITY = 24'h400000;
  localparam logic [23:0] SAT_MAX = 24'h7FFFFF;
  localparam logic [23:0] SAT_MIN = 24'h800000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } aucal_sample_t;
endpackage : aucal_pkg

// ### rtl/aucal_datapath.sv
// Two-stage offset and gain correction pipeline with saturation.
`timescale 1ns/1ps
module aucal_datapath (
  input wire logic core_clk,
  input wire logic reset_n,
  input aucal_pkg::aucal_sample_t sampleIn,
  input wire logic [23:0] offsetWord,
  input wire logic [23:0] gainWord,
  output aucal_pkg::aucal_sample_t sampleOut
);
  wire logic [24:0] diffWide;
  assign diffWide = {sampleIn.data[23], sampleIn.data}
                  - {offsetWord[23], offsetWord};
  wire logic diffFits;
  assign diffFits = diffWide[24] == diffWide[23];
  wire logic [23:0] diffSat;
  assign diffSat = diffFits ? diffWide[23:0] :
                   (diffWide[24] ? aucal_pkg::SAT_MIN : aucal_pkg::SAT_MAX);
  logic stageValid;
  logic [23:0] stageData;
  logic [23:0] stageGain;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stageValid <= 1'b0;
      stageData <= 24'h000000;
      stageGain <= 24'h000000;
    end else begin
      stageValid <= sampleIn.valid;
      stageData <= diffSat;
      stageGain <= gainWord;
    end
  end
  wire logic signed [48:0] prodWide;
  assign prodWide = $signed(stageData) * $signed({1'b0, stageGain});
  wire logic prodFits;
  assign prodFits = (prodWide[48:45] == 4'h0) || (prodWide[48:45] == 4'hF);
  wire logic [23:0] scaled;
  assign scaled = prodFits ? prodWide[45:22] :
                  (prodWide[48] ? aucal_pkg::SAT_MIN : aucal_pkg::SAT_MAX);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sampleOut <= '0;
    end else begin
      sampleOut.valid <= stageValid;
      sampleOut.data <= scaled;
    end
  end

  property p_offset_unity;
    @(posedge core_clk) disable iff (!reset_n)
    sampleIn.valid && diffFits && gainWord == aucal_pkg::GAIN_UNITY
    |-> ##2 sampleOut.valid
        && sampleOut.data == $past(sampleIn.data, 2) - $past(offsetWord, 2);
  endproperty
  a_offset_unity: assert property (p_offset_unity)
    else $error("offset subtract wrong at unity gain");
  property p_order;
    @(posedge core_clk) disable iff (!reset_n)
    sampleIn.valid && sampleIn.data == offsetWord
    |-> ##2 sampleOut.data == 24'h000000;
  endproperty
  a_order: assert property (p_order)
    else $error("gain applied before offset");
  property p_gain_scale;
    @(posedge core_clk) disable iff (!reset_n)
    sampleIn.valid && offsetWord == 24'h000000
      && sampleIn.data[23:20] == 4'h0
    |-> ##2 sampleOut.data == 24'((48'($past(sampleIn.data, 2))
        * 48'($past(gainWord, 2))) >> 22);
  endproperty
  a_gain_scale: assert property (p_gain_scale)
    else $error("gain scaling wrong");
  property p_unity_pass;
    @(posedge core_clk) disable iff (!reset_n)
    sampleIn.valid && offsetWord == 24'h000000
      && gainWord == aucal_pkg::GAIN_UNITY
    |-> ##2 sampleOut.data == $past(sampleIn.data, 2);
  endproperty
  a_unity_pass: assert property (p_unity_pass)
    else $error("unity gain code does not pass data");
  property p_clip_high;
    @(posedge core_clk) disable iff (!reset_n)
    sampleIn.valid && sampleIn.data == aucal_pkg::SAT_MAX
      && offsetWord == aucal_pkg::SAT_MIN
      && gainWord >= aucal_pkg::GAIN_UNITY
    |-> ##2 sampleOut.data == aucal_pkg::SAT_MAX;
  endproperty
  a_clip_high: assert property (p_clip_high)
    else $error("positive overflow not clipped");
  property p_clip_low;
    @(posedge core_clk) disable iff (!reset_n)
    sampleIn.valid && sampleIn.data == aucal_pkg::SAT_MIN
      && offsetWord == 24'h000001 && gainWord >= aucal_pkg::GAIN_UNITY
    |-> ##2 sampleOut.data == aucal_pkg::SAT_MIN;
  endproperty
  a_clip_low: assert property (p_clip_low)
    else $error("negative overflow not clipped");
  c_clip: cover property (@(posedge core_clk) sampleOut.valid
    && sampleOut.data == aucal_pkg::SAT_MAX);
endmodule : aucal_datapath

// ### rtl/aucal_top.sv
// Register file, AXI4-Lite slave, check compare and calibration top.
`timescale 1ns/1ps
// Operation
// - The offset word is signed and is subtracted from every sample.
// - Offset correction comes first and gain scaling acts on its result.
// - The gain word is unsigned with 400000h meaning a gain of one.
// - The corrected sample is multiplied by gain over 400000h.
// - Gain bytes sit at Ch, Dh and Eh and reset to 40h, 00h and 00h.
// - The gain word is built from three bytes, lowest address on top.
// - A mismatch with the internal value sets the error in header and status.
// - The comparison runs only while the check enable bit is set.
// - With the check disabled the check register is a plain scratchpad.
module aucal_top #(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input aucal_pkg::aucal_sample_t sampleIn,
  input wire logic [7:0] calcCheck,
  output aucal_pkg::aucal_sample_t sampleOut,
  output logic [7:0] statusHeader,
  output logic irq
);
  logic [7:0] offsetHigh;
  logic [7:0] offsetMid;
  logic [7:0] offsetLow;
  logic [7:0] gainHigh;
  logic [7:0] gainMid;
  logic [7:0] gainLow;
  logic [7:0] checkValue;
  logic [7:0] control;
  logic [1:0] status;
  logic [1:0] mask;
  logic [23:0] lastResult;
  logic awHeld;
  logic wHeld;
  logic [aucal_pkg::IDX_W-1:0] wrIdx;
  logic [7:0] wrByte;
  logic wrLane;

  // Write channel: address and data are taken independently.
  wire logic awTake;
  assign awTake = s_axi_awvalid && s_axi_awready;
  wire logic wTake;
  assign wTake = s_axi_wvalid && s_axi_wready;
  wire logic regWrite;
  assign regWrite = awHeld && wHeld && !s_axi_bvalid;
  wire logic bDone;
  assign bDone = s_axi_bvalid && s_axi_bready;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      awHeld <= 1'b0;
      wrIdx <= '0;
    end else if (awTake) begin
      s_axi_awready <= 1'b0;
      awHeld <= 1'b1;
      wrIdx <= s_axi_awaddr[ADDR_W-1:2];
    end else if (regWrite) begin
      awHeld <= 1'b0;
    end else if (bDone) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_wready <= 1'b1;
      wHeld <= 1'b0;
      wrByte <= 8'h00;
      wrLane <= 1'b0;
    end else if (wTake) begin
      s_axi_wready <= 1'b0;
      wHeld <= 1'b1;
      wrByte <= s_axi_wdata[7:0];
      wrLane <= s_axi_wstrb[0];
    end else if (regWrite) begin
      wHeld <= 1'b0;
    end else if (bDone) begin
      s_axi_wready <= 1'b1;
    end
  end

  wire logic wOffHi;
  assign wOffHi = wrIdx == aucal_pkg::IDX_OFFSET_HIGH;
  wire logic wOffMid;
  assign wOffMid = wrIdx == aucal_pkg::IDX_OFFSET_MID;
  wire logic wOffLow;
  assign wOffLow = wrIdx == aucal_pkg::IDX_OFFSET_LOW;
  wire logic wGainHi;
  assign wGainHi = wrIdx == aucal_pkg::IDX_GAIN_HIGH;
  wire logic wGainMid;
  assign wGainMid = wrIdx == aucal_pkg::IDX_GAIN_MID;
  wire logic wGainLow;
  assign wGainLow = wrIdx == aucal_pkg::IDX_GAIN_LOW;
  wire logic wCheck;
  assign wCheck = wrIdx == aucal_pkg::IDX_CHECK;
  wire logic wCtrl;
  assign wCtrl = wrIdx == aucal_pkg::IDX_CONTROL;
  wire logic wStat;
  assign wStat = wrIdx == aucal_pkg::IDX_STATUS;
  wire logic wMask;
  assign wMask = wrIdx == aucal_pkg::IDX_MASK;
  wire logic wResult;
  assign wResult = wrIdx == aucal_pkg::IDX_RESULT;
  wire logic wMapped;
  assign wMapped = wOffHi || wOffMid || wOffLow || wGainHi || wGainMid
                || wGainLow || wCheck || wCtrl || wStat || wMask || wResult;
  wire logic wEn;
  assign wEn = regWrite && wrLane;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= aucal_pkg::RESP_OKAY;
    end else if (regWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wMapped ? aucal_pkg::RESP_OKAY : aucal_pkg::RESP_SLVERR;
    end else if (bDone) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      offsetHigh <= aucal_pkg::OFFSET_RESET;
      offsetMid <= aucal_pkg::OFFSET_RESET;
      offsetLow <= aucal_pkg::OFFSET_RESET;
    end else if (wEn) begin
      if (wOffHi) offsetHigh <= wrByte;
      if (wOffMid) offsetMid <= wrByte;
      if (wOffLow) offsetLow <= wrByte;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gainHigh <= aucal_pkg::GAIN_HIGH_RESET;
      gainMid <= aucal_pkg::GAIN_MID_RESET;
      gainLow <= aucal_pkg::GAIN_LOW_RESET;
    end else if (wEn) begin
      if (wGainHi) gainHigh <= wrByte;
      if (wGainMid) gainMid <= wrByte;
      if (wGainLow) gainLow <= wrByte;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      checkValue <= aucal_pkg::CHECK_RESET;
      control <= aucal_pkg::CONTROL_RESET;
      mask <= aucal_pkg::MASK_RESET;
    end else if (wEn) begin
      if (wCheck) checkValue <= wrByte;
      if (wCtrl) control <= wrByte;
      if (wMask) mask <= wrByte[aucal_pkg::ST_W-1:0];
    end
  end

  wire logic [23:0] gainWord;
  assign gainWord = {gainHigh, gainMid, gainLow};
  wire logic [23:0] offsetWord;
  assign offsetWord = {offsetHigh, offsetMid, offsetLow};

  aucal_datapath u_aucal_datapath (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sampleIn(sampleIn),
    .offsetWord(offsetWord),
    .gainWord(gainWord),
    .sampleOut(sampleOut)
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lastResult <= 24'h000000;
    end else if (sampleOut.valid) begin
      lastResult <= sampleOut.data;
    end
  end

  wire logic checkEn;
  assign checkEn = control[aucal_pkg::CTRL_CHECK_EN_BIT];
  wire logic mismatch;
  assign mismatch = checkEn && (checkValue != calcCheck);
  wire logic [1:0] statusSet;
  assign statusSet = {sampleOut.valid, mismatch};
  wire logic [1:0] statusClr;
  assign statusClr = (wEn && wStat) ? wrByte[1:0] : 2'h0;

  // A new event wins over a clear written in the same cycle.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= 2'h0;
    end else begin
      status <= (status & ~statusClr) | statusSet;
    end
  end

  wire logic [7:0] next_statusHeader;
  assign next_statusHeader =
    8'(status[aucal_pkg::ST_REG_ERR_BIT]) << aucal_pkg::HDR_REG_ERR_BIT;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      statusHeader <= 8'h00;
      irq <= 1'b0;
    end else begin
      statusHeader <= next_statusHeader;
      irq <= |(status & mask);
    end
  end

  // Read channel: one read at a time, answered on the next cycle.
  wire logic [aucal_pkg::IDX_W-1:0] rdIdx;
  assign rdIdx = s_axi_araddr[ADDR_W-1:2];
  wire logic [10:0] rHit;
  assign rHit = {rdIdx == aucal_pkg::IDX_RESULT,
                 rdIdx == aucal_pkg::IDX_MASK,
                 rdIdx == aucal_pkg::IDX_STATUS,
                 rdIdx == aucal_pkg::IDX_CONTROL,
                 rdIdx == aucal_pkg::IDX_CHECK,
                 rdIdx == aucal_pkg::IDX_GAIN_LOW,
                 rdIdx == aucal_pkg::IDX_GAIN_MID,
                 rdIdx == aucal_pkg::IDX_GAIN_HIGH,
                 rdIdx == aucal_pkg::IDX_OFFSET_LOW,
                 rdIdx == aucal_pkg::IDX_OFFSET_MID,
                 rdIdx == aucal_pkg::IDX_OFFSET_HIGH};
  wire logic [31:0] readWord;
  assign readWord = ({32{rHit[0]}} & {24'h000000, offsetHigh})
                  | ({32{rHit[1]}} & {24'h000000, offsetMid})
                  | ({32{rHit[2]}} & {24'h000000, offsetLow})
                  | ({32{rHit[3]}} & {24'h000000, gainHigh})
                  | ({32{rHit[4]}} & {24'h000000, gainMid})
                  | ({32{rHit[5]}} & {24'h000000, gainLow})
                  | ({32{rHit[6]}} & {24'h000000, checkValue})
                  | ({32{rHit[7]}} & {24'h000000, control})
                  | ({32{rHit[8]}} & {30'h0, status})
                  | ({32{rHit[9]}} & {30'h0, mask})
                  | ({32{rHit[10]}} & {8'h00, lastResult});
  wire logic arTake;
  assign arTake = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= aucal_pkg::RESP_OKAY;
    end else if (arTake) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readWord;
      s_axi_rresp <= (|rHit) ? aucal_pkg::RESP_OKAY : aucal_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  property p_gain_reset;
    @(posedge core_clk) disable iff (!reset_n)
    !$past(reset_n) |-> gainWord == aucal_pkg::GAIN_UNITY;
  endproperty
  a_gain_reset: assert property (p_gain_reset)
    else $error("gain word not unity after reset");
  property p_gain_high_byte;
    @(posedge core_clk) disable iff (!reset_n)
    wEn && wGainHi |=> gainWord[23:16] == $past(wrByte)
                       && gainWord[15:0] == $past(gainWord[15:0]);
  endproperty
  a_gain_high_byte: assert property (p_gain_high_byte)
    else $error("gain high byte misplaced");
  property p_gain_low_byte;
    @(posedge core_clk) disable iff (!reset_n)
    wEn && wGainLow |=> gainWord[7:0] == $past(wrByte)
                       && gainWord[23:8] == $past(gainWord[23:8]);
  endproperty
  a_gain_low_byte: assert property (p_gain_low_byte)
    else $error("gain low byte misplaced");
  property p_mismatch_flag;
    @(posedge core_clk) disable iff (!reset_n)
    checkEn && checkValue != calcCheck
    |=> status[aucal_pkg::ST_REG_ERR_BIT]
        ##1 statusHeader[aucal_pkg::HDR_REG_ERR_BIT];
  endproperty
  a_mismatch_flag: assert property (p_mismatch_flag)
    else $error("mismatch did not raise error in status and header");
  property p_check_disabled;
    @(posedge core_clk) disable iff (!reset_n)
    !checkEn && !status[aucal_pkg::ST_REG_ERR_BIT]
    |=> !status[aucal_pkg::ST_REG_ERR_BIT];
  endproperty
  a_check_disabled: assert property (p_check_disabled)
    else $error("error raised while check disabled");
  property p_scratchpad;
    @(posedge core_clk) disable iff (!reset_n)
    wEn && wCheck |=> checkValue == $past(wrByte);
  endproperty
  a_scratchpad: assert property (p_scratchpad)
    else $error("check register did not store written byte");
  property p_write_answer;
    @(posedge core_clk) disable iff (!reset_n)
    awTake ##[0:8] (awHeld && wHeld) |=> s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response missing");
  c_mismatch: cover property (@(posedge core_clk) disable iff (!reset_n)
    mismatch ##1 status[aucal_pkg::ST_REG_ERR_BIT]);
  c_gain_write: cover property (@(posedge core_clk) disable iff (!reset_n)
    wEn && wGainHi);
  c_irq: cover property (@(posedge core_clk) disable iff (!reset_n) irq);
endmodule : aucal_top

// ### sim/aucal_host.sv
// Register bus master that plays the host controller.
`timescale 1ns/1ps
module aucal_host (
  input wire logic core_clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  output logic hang
);
  // host runs 1:1 on the core clock
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready, hang} = '0;
  end

  // Released address and data lines show the inverse of their last value.
  task automatic write(input logic [7:0] a, input logic [7:0] d,
                       output logic [1:0] resp);
    bit aDone;
    bit wDone;
    bit bDone;
    int n;
    {aDone, wDone, bDone} = '0;
    resp = 2'h3;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 64 && !(aDone && wDone); n++) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1 && !aDone) begin
        aDone = 1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wready === 1'b1 && !wDone) begin
        wDone = 1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~{24'h000000, d};
      end
    end
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64 && !bDone; n++) begin
      @(posedge core_clk);
      if (s_axi_bvalid === 1'b1) begin
        bDone = 1;
        resp = s_axi_bresp;
      end
    end
    s_axi_bready <= 1'b0;
    if (!(aDone && wDone && bDone)) hang <= 1'b1;
  endtask : write

  task automatic read(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] resp);
    bit aDone;
    bit rDone;
    int n;
    {aDone, rDone} = '0;
    resp = 2'h3;
    d = '0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64 && !rDone; n++) begin
      @(posedge core_clk);
      if (aDone && s_axi_rvalid === 1'b1) begin
        rDone = 1;
        d = s_axi_rdata;
        resp = s_axi_rresp;
      end
      if (s_axi_arready === 1'b1 && !aDone) begin
        aDone = 1;
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end
    s_axi_rready <= 1'b0;
    if (!rDone) hang <= 1'b1;
  endtask : read

  task automatic writeCheck(input logic [7:0] v);
    logic [1:0] r;
    write(8'h3C, v, r);
  endtask : writeCheck
endmodule : aucal_host

// ### sim/aucal_top_tb.sv
// Self-checking bench of the calibration and register check block.
`timescale 1ns/1ps
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin errCount++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module aucal_top_tb;
  logic core_clk;
  logic reset_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr, calcCheck, statusHeader;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed = 32'h9, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, irq, hang;
  aucal_pkg::aucal_sample_t sampleIn, sampleOut;
  int errCount = 0;
  int testsRun = 0;
  logic [23:0] smpQ[$], offR, gainR, lastExp, expS;
  logic [31:0] rdQ[$], expR;
  logic [7:0] rstA[11] = '{8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C,
                           8'h40, 8'h44, 8'h48, 8'h4C};
  logic [31:0] rstV[11] = '{0, 0, 0, 32'h40, 0, 0, 0, 0, 0, 0, 0};
  logic [23:0] offs[3] = '{24'h000000, 24'h800000, 24'h7FFFFF};
  logic [23:0] gains[3] = '{24'h400000, 24'h400000, 24'hFFFFFF};

  aucal_top u_aucal_top (.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sampleIn, .calcCheck, .sampleOut, .statusHeader, .irq);
  aucal_host u_aucal_host (.core_clk, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .hang);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic longint clip(longint v);
    if (v > 64'sh7FFFFF) return 64'sh7FFFFF;
    if (v < -64'sh800000) return -64'sh800000;
    return v;
  endfunction : clip

  // Expected result: offset first, then gain, clipped after each stage.
  function automatic logic [23:0] calc(logic [23:0] x);
    longint d;
    d = clip(longint'($signed(x)) - longint'($signed(offR)));
    d = clip((d * longint'({40'h0, gainR})) >>> 22);
    return d[23:0];
  endfunction : calc

  task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] er);
    u_aucal_host.write(a, d, resp);
    `CHK(resp, er)
  endtask : wr

  task automatic rdChk(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    rdQ.push_back(e);
    u_aucal_host.read(a, rd, resp);
    `CHK(resp, er)
  endtask : rdChk

  task automatic setWord(logic [7:0] b, logic [23:0] w);
    wr(b, w[23:16], 2'h0);
    wr(b + 8'h4, w[15:8], 2'h0);
    wr(b + 8'h8, w[7:0], 2'h0);
  endtask : setWord

  task automatic send(int n);
    logic [23:0] x;
    for (int i = 0; i < n; i++) begin
      rd = xs();
      x = (i == 0) ? 24'h7FFFFF : (i == 1) ? 24'h800000 : rd[23:0];
      @(posedge core_clk);
      sampleIn <= {1'b1, x};
      lastExp = calc(x);
      smpQ.push_back(lastExp);
    end
    @(posedge core_clk);
    sampleIn <= '0;
    repeat (4) @(posedge core_clk);
  endtask : send

  always @(posedge core_clk) begin
    if (sampleOut.valid === 1'b1) begin
      `CHK(smpQ.size() != 0, 1'b1)
      if (smpQ.size() != 0) begin
        expS = smpQ.pop_front();
        `CHK(sampleOut.data, expS)
      end
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      `CHK(rdQ.size() != 0, 1'b1)
      if (rdQ.size() != 0) begin
        expR = rdQ.pop_front();
        `CHK(s_axi_rdata, expR)
      end
    end
    if (hang === 1'b1) begin
      errCount++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  initial begin
    sampleIn = '0;
    calcCheck = 8'h5A;
    reset_n = 1'b0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (rstA[i]) rdChk(rstA[i], rstV[i], 2'h0);
    $display("test reset done");
    setWord(8'h30, 24'h123456);
    rdChk(8'h30, 32'h12, 2'h0);
    rdChk(8'h34, 32'h34, 2'h0);
    rdChk(8'h38, 32'h56, 2'h0);
    wr(8'h3C, 8'h33, 2'h0);
    rdChk(8'h3C, 32'h33, 2'h0);
    rdChk(8'h44, 32'h0, 2'h0);
    `CHK(statusHeader, 8'h00)
    wr(8'hFC, 8'h01, 2'h2);
    rdChk(8'hFC, 32'h0, 2'h2);
    $display("test registers done");
    wr(8'h48, 8'h01, 2'h0);
    wr(8'h40, 8'h01, 2'h0);
    repeat (3) @(posedge core_clk);
    rdChk(8'h44, 32'h1, 2'h0);
    `CHK(statusHeader, 8'h04)
    `CHK(irq, 1'b1)
    u_aucal_host.writeCheck(calcCheck);
    wr(8'h44, 8'h01, 2'h0);
    repeat (3) @(posedge core_clk);
    rdChk(8'h44, 32'h0, 2'h0);
    `CHK(statusHeader, 8'h00)
    `CHK(irq, 1'b0)
    @(posedge core_clk);
    calcCheck <= 8'hA5;
    repeat (3) @(posedge core_clk);
    `CHK(statusHeader, 8'h04)
    wr(8'h40, 8'h00, 2'h0);
    wr(8'h44, 8'h01, 2'h0);
    repeat (3) @(posedge core_clk);
    `CHK(statusHeader, 8'h00)
    $display("test check done");
    for (int i = 0; i < 4; i++) begin
      rd = xs();
      offR = (i < 3) ? offs[i] : rd[23:0];
      rd = xs();
      gainR = (i < 3) ? gains[i] : rd[23:0];
      setWord(8'h24, offR);
      setWord(8'h30, gainR);
      send(6);
    end
    rdChk(8'h4C, {8'h00, lastExp}, 2'h0);
    wr(8'h4C, 8'hFF, 2'h0);
    rdChk(8'h4C, {8'h00, lastExp}, 2'h0);
    `CHK(smpQ.size(), 0)
    rdChk(8'h44, 32'h2, 2'h0);
    wr(8'h48, 8'h02, 2'h0);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 1'b1)
    wr(8'h44, 8'h02, 2'h0);
    repeat (2) @(posedge core_clk);
    rdChk(8'h44, 32'h0, 2'h0);
    `CHK(irq, 1'b0)
    $display("test samples done");
    summarize();
  end
endmodule : aucal_top_tb
